/* verilog/servo_warning_alarm_monitor.sv */
`include "warn_alarm_regs.svh"

module servo_warning_alarm_monitor
  import warn_alarm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire meas_t meas,
  input wire thresh_t thresh,
  input wire logic servo_on_in,
  input wire logic main_power_ok,
  input wire logic batt_or_enc_lost,
  input wire logic gear_range_err,
  input wire logic hist_clear,
  input wire logic [3:0] hist_index,
  output logic [7:0] hist_code,
  output logic [3:0] hist_count,
  output logic warning_out,
  output logic [9:0] warn_active,
  input wire logic alarm_event,
  input wire logic [7:0] alarm_id,
  input wire logic [3:0] alarm_blinks,
  input wire logic alarm_stops_excitation,
  input wire logic alarm_reset_in,
  input wire logic brake_fitted,
  output logic alarm_out_n,
  output logic [7:0] alarm_id_out,
  output logic alarm_led,
  output logic motor_current_enable,
  output logic brake_engage,
  input wire logic alarm_code_enable,
  input wire logic [2:0] code_table_wdata,
  input wire logic [7:0] code_table_waddr,
  input wire logic code_table_we,
  input wire ctrl_mode_t ctrl_mode,
  input wire status_out_t status_in,
  input wire logic torque_limit_active,
  input wire logic speed_limit_active,
  output status_out_t status_out
);

  // ************************************************************
  // Warning detection
  // ************************************************************
  logic [9:0] cond;
  logic [7:0] code_of [0:`WARN_COUNT-1];
  logic [9:0] warn_ff;
  logic [9:0] rise;

  assign code_of[0] = `CODE_POS_DEV;
  assign code_of[1] = `CODE_OVERHEAT;
  assign code_of[2] = `CODE_OVERVOLT;
  assign code_of[3] = `CODE_MAIN_OFF;
  assign code_of[4] = `CODE_UNDERVOLT;
  assign code_of[5] = `CODE_LOW_BATT;
  assign code_of[6] = `CODE_OVERLOAD;
  assign code_of[7] = `CODE_OVERSPEED;
  assign code_of[8] = `CODE_ABS_LOST;
  assign code_of[9] = `CODE_GEAR_ERR;

  always_comb begin
    cond[0] = meas.pos_dev_rev > thresh.pos_dev;
    cond[1] = meas.temp_c > thresh.overheat;
    cond[2] = meas.dc_bus_v > thresh.overvolt;
    cond[3] = servo_on_in && !main_power_ok;
    cond[4] = meas.dc_bus_v < thresh.undervolt;
    cond[5] = meas.batt_mv <= `BATT_LOW_MV;
    cond[6] = meas.torque_pct > thresh.overload;
    cond[7] = meas.speed_rpm > thresh.overspeed;
    cond[8] = batt_or_enc_lost;
    cond[9] = gear_range_err;
  end

  // Warnings never touch motor current; only alarms do
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      warn_ff <= 10'h000;
    end else begin
      warn_ff <= cond;
    end
  end

  assign warn_active = warn_ff;
  assign warning_out = |warn_ff;
  assign rise = cond & ~warn_ff;

  // ************************************************************
  // Warning history
  // ************************************************************
  // Warnings rising together queue in a pending mask and log one
  // per cycle, lowest index first; a clear keeps the rises of its
  // own cycle queued so none is lost.
  logic [9:0] pend_ff;
  logic [7:0] hist_ff [0:`HIST_DEPTH-1];
  logic [3:0] cnt_ff;
  logic [3:0] sel;
  logic found;
  logic [9:0] pend_now;

  always_comb begin
    pend_now = pend_ff | rise;
    sel = 4'h0;
    found = 1'b0;
    for (int i = `WARN_COUNT - 1; i >= 0; i--) begin
      if (pend_now[i]) begin
        sel = 4'(i);
        found = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pend_ff <= 10'h000;
    end else if (hist_clear) begin
      pend_ff <= rise;
    end else begin
      pend_ff <= pend_now & ~(found ? (10'h001 << sel) : 10'h000);
    end
  end

  genvar g;
  generate
    for (g = 0; g < `HIST_DEPTH; g++) begin : g_hist
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          hist_ff[g] <= 8'h00;
        end else if (hist_clear) begin
          hist_ff[g] <= 8'h00;
        end else if (found) begin
          if (g == 0) begin
            hist_ff[g] <= code_of[sel];
          end else begin
            hist_ff[g] <= hist_ff[(g > 0) ? g - 1 : 0];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_ff <= 4'h0;
    end else if (hist_clear) begin
      cnt_ff <= 4'h0;
    end else if (found && cnt_ff != 4'(`HIST_DEPTH)) begin
      cnt_ff <= cnt_ff + 4'h1;
    end
  end

  assign hist_count = cnt_ff;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hist_code <= 8'h00;
    end else if (hist_index < cnt_ff) begin
      hist_code <= hist_ff[hist_index];
    end else begin
      hist_code <= 8'h00;
    end
  end

  // ************************************************************
  // Alarm latch
  // ************************************************************
  logic alarm_ff;
  logic [7:0] alarm_id_ff;
  logic [3:0] blinks_ff;
  logic stop_exc_ff;
  logic rst_in_ff;
  logic reset_fall;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rst_in_ff <= 1'b0;
    end else begin
      rst_in_ff <= alarm_reset_in;
    end
  end

  assign reset_fall = rst_in_ff && !alarm_reset_in;

  // A new alarm in the reset cycle wins over the clear
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      alarm_ff <= 1'b0;
      alarm_id_ff <= 8'h00;
      blinks_ff <= 4'h0;
      stop_exc_ff <= 1'b0;
    end else if (alarm_event) begin
      if (!alarm_ff) begin
        alarm_id_ff <= alarm_id;
        blinks_ff <= alarm_blinks;
        stop_exc_ff <= alarm_stops_excitation;
      end
      alarm_ff <= 1'b1;
    end else if (reset_fall) begin
      alarm_ff <= 1'b0;
      stop_exc_ff <= 1'b0;
    end
  end

  assign alarm_id_out = alarm_id_ff;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      alarm_out_n <= 1'b0;
      motor_current_enable <= 1'b0;
      brake_engage <= 1'b0;
    end else begin
      alarm_out_n <= !alarm_ff;
      motor_current_enable <= !(alarm_ff && stop_exc_ff);
      brake_engage <= alarm_ff && stop_exc_ff && brake_fitted;
    end
  end

  // ************************************************************
  // Alarm LED blinker
  // ************************************************************
  blink_state_t bst_ff;
  logic [31:0] tmr_ff;
  logic [3:0] bcnt_ff;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bst_ff <= BLINK_IDLE;
      tmr_ff <= 32'h0000_0000;
      bcnt_ff <= 4'h0;
    end else if (!alarm_ff) begin
      bst_ff <= BLINK_IDLE;
      tmr_ff <= 32'h0000_0000;
      bcnt_ff <= 4'h0;
    end else begin
      tmr_ff <= tmr_ff + 32'h0000_0001;
      case (bst_ff)
        BLINK_IDLE: begin
          bst_ff <= BLINK_ON;
          tmr_ff <= 32'h0000_0000;
          bcnt_ff <= 4'h1;
        end
        BLINK_ON: begin
          if (tmr_ff >= 32'(`BLINK_ON_CYC - 1)) begin
            bst_ff <= BLINK_OFF;
            tmr_ff <= 32'h0000_0000;
          end
        end
        BLINK_OFF: begin
          if (tmr_ff >= 32'(`BLINK_ON_CYC - 1)) begin
            tmr_ff <= 32'h0000_0000;
            // Count of pulses per burst tells the cause
            if (bcnt_ff >= blinks_ff) begin
              bst_ff <= BLINK_GAP;
            end else begin
              bst_ff <= BLINK_ON;
              bcnt_ff <= bcnt_ff + 4'h1;
            end
          end
        end
        BLINK_GAP: begin
          if (tmr_ff >= 32'(`BLINK_GAP_CYC - 1)) begin
            bst_ff <= BLINK_ON;
            tmr_ff <= 32'h0000_0000;
            bcnt_ff <= 4'h1;
          end
        end
        default: bst_ff <= BLINK_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      alarm_led <= 1'b0;
    end else begin
      alarm_led <= (bst_ff == BLINK_ON);
    end
  end

  // ************************************************************
  // Alarm code table and status routing
  // ************************************************************
  logic [2:0] code_tbl [0:255];
  logic [2:0] acode;
  logic lim;

  // Table has no reset; software must load it before enabling codes
  always_ff @(posedge clk_sys) begin
    if (code_table_we) begin
      code_tbl[code_table_waddr] <= code_table_wdata;
    end
  end

  assign acode = code_tbl[alarm_id_ff];

  always_comb begin
    if (ctrl_mode == CTRL_POSITION || ctrl_mode == CTRL_SPEED) begin
      lim = torque_limit_active;
    end else begin
      lim = speed_limit_active;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      status_out <= '0;
    end else if (alarm_code_enable && alarm_ff) begin
      status_out.ready <= acode[0];
      status_out.limit_active <= acode[1];
      status_out.zero_speed <= acode[2];
    end else begin
      status_out.ready <= status_in.ready;
      status_out.limit_active <= lim;
      status_out.zero_speed <= status_in.zero_speed;
    end
  end

endmodule : servo_warning_alarm_monitor

/* verilog/warn_alarm_regs.svh */
`ifndef WARN_ALARM_REGS_SVH
`define WARN_ALARM_REGS_SVH

`define CODE_POS_DEV 8'h0A
`define CODE_OVERHEAT 8'h15
`define CODE_OVERVOLT 8'h16
`define CODE_MAIN_OFF 8'h17
`define CODE_UNDERVOLT 8'h19
`define CODE_LOW_BATT 8'h1B
`define CODE_OVERLOAD 8'h1E
`define CODE_OVERSPEED 8'h1F
`define CODE_ABS_LOST 8'h21
`define CODE_GEAR_ERR 8'h47

`define DEF_POS_DEV_REV 16'h0009
`define DEF_OVERHEAT_C 16'h0050
`define DEF_OVERVOLT_V 16'h0186
`define DEF_UNDERVOLT_V 16'h007D
`define DEF_OVERLOAD_PCT 16'h005A
`define DEF_OVERSPEED_RPM 16'h16A8
`define BATT_LOW_MV 16'h0C80

`define HIST_DEPTH 10
`define WARN_COUNT 10

`define CLK_HZ 40000000
`define BLINK_ON_MS 200
`define BLINK_GAP_MS 1000
`define BLINK_ON_CYC (`CLK_HZ / 1000 * `BLINK_ON_MS)
`define BLINK_GAP_CYC (`CLK_HZ / 1000 * `BLINK_GAP_MS)

`endif

/* verilog/warn_alarm_pkg.sv */
package warn_alarm_pkg;

  typedef struct packed {
    logic [15:0] pos_dev_rev;
    logic [15:0] temp_c;
    logic [15:0] dc_bus_v;
    logic [15:0] batt_mv;
    logic [15:0] torque_pct;
    logic [15:0] speed_rpm;
  } meas_t;

  typedef struct packed {
    logic [15:0] pos_dev;
    logic [15:0] overheat;
    logic [15:0] overvolt;
    logic [15:0] undervolt;
    logic [15:0] overload;
    logic [15:0] overspeed;
  } thresh_t;

  typedef struct packed {
    logic ready;
    logic limit_active;
    logic zero_speed;
  } status_out_t;

  typedef enum logic [1:0] {
    CTRL_POSITION = 2'b00,
    CTRL_SPEED = 2'b01,
    CTRL_TORQUE = 2'b10,
    CTRL_TENSION = 2'b11
  } ctrl_mode_t;

  typedef enum logic [1:0] {
    BLINK_IDLE = 2'b00,
    BLINK_ON = 2'b01,
    BLINK_OFF = 2'b10,
    BLINK_GAP = 2'b11
  } blink_state_t;

endpackage : warn_alarm_pkg

/* verif/warn_alarm_props.sv */
module warn_alarm_props
  import warn_alarm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire meas_t meas,
  input wire thresh_t thresh,
  input wire logic servo_on_in,
  input wire logic main_power_ok,
  input wire logic alarm_event,
  input wire logic alarm_reset_in,
  input wire logic alarm_code_enable,
  input wire ctrl_mode_t ctrl_mode,
  input wire logic torque_limit_active,
  input wire logic speed_limit_active,
  input wire logic warning_out,
  input wire logic [9:0] warn_active,
  input wire logic alarm_out_n,
  input wire logic motor_current_enable,
  input wire logic brake_engage,
  input wire status_out_t status_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********
  // Checks
  // ********
  logic [1:0] age_ff;
  // Keeps $past away from values seen during reset
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      age_ff <= 2'h0;
    end else if (age_ff != 2'h3) begin
      age_ff <= age_ff + 2'h1;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence reset_fall;
    alarm_reset_in ##1 !alarm_reset_in;
  endsequence
  chk_heat_warn: assert property (meas.temp_c > thresh.overheat |=> warn_active[1])
    else $error("overheat not flagged");
  chk_warn_clear: assert property (meas.temp_c <= thresh.overheat |=> !warn_active[1])
    else $error("overheat stuck");
  chk_main_off: assert property (servo_on_in && !main_power_ok |=> warn_active[3])
    else $error("main power warning missing");
  chk_batt_low: assert property (meas.batt_mv <= 16'h0C80 |=> warn_active[5])
    else $error("battery warning missing");
  chk_warn_or: assert property (warning_out == |warn_active)
    else $error("warning output wrong");
  chk_alarm_low: assert property (alarm_event |-> ##2 !alarm_out_n)
    else $error("alarm output not low");
  chk_fall_clears: assert property (reset_fall ##0 !alarm_event |-> ##2 alarm_out_n)
    else $error("alarm not cleared");
  chk_level_hold: assert property (age_ff == 2'h3 && $rose(alarm_out_n) |->
    !$past(alarm_reset_in, 2) && $past(alarm_reset_in, 3))
    else $error("alarm cleared without fall");
  chk_cur_normal: assert property (alarm_out_n |-> motor_current_enable && !brake_engage)
    else $error("current cut without alarm");
  chk_limit_sel: assert property (!alarm_code_enable && !ctrl_mode[1] |=>
    status_out.limit_active == $past(torque_limit_active))
    else $error("torque limit output wrong");
  chk_limit_speed: assert property (!alarm_code_enable && ctrl_mode[1] |=>
    status_out.limit_active == $past(speed_limit_active))
    else $error("speed limit output wrong");
endmodule : warn_alarm_props

bind servo_warning_alarm_monitor warn_alarm_props i_props (.*);

/* verif/plc_model.sv */
module plc_model (
  input wire logic clk_sys,
  input wire logic alarm_out_n,
  input wire logic clr_req,
  output logic servo_on_in,
  output logic alarm_reset_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    servo_on_in = 1'b0;
    alarm_reset_in = 1'b0;
  end
  // Motion command dropped once alarm seen
  always @(posedge clk_sys) begin
    servo_on_in <= alarm_out_n;
  end
  // One reset pulse per request, cause gone first
  always @(posedge clk_sys) begin
    alarm_reset_in <= clr_req;
  end
endmodule : plc_model

/* verif/tb.sv */
`include "warn_alarm_regs.svh"

module tb
  import warn_alarm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam meas_t NOM = '{16'h0000, 16'h0014, 16'h0136, 16'h0E10, 16'h0000, 16'h0000};
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  meas_t meas, v;
  thresh_t thresh;
  logic servo_on_in, main_power_ok, batt_or_enc_lost, gear_range_err, hist_clear, clr_req;
  logic alarm_event, alarm_stops_excitation, alarm_reset_in, brake_fitted, alarm_code_enable;
  logic code_table_we, torque_limit_active, speed_limit_active, warning_out, alarm_out_n;
  logic alarm_led, motor_current_enable, brake_engage;
  logic [3:0] hist_index, hist_count, alarm_blinks;
  logic [7:0] hist_code, alarm_id, alarm_id_out, code_table_waddr;
  logic [2:0] code_table_wdata;
  logic [9:0] warn_active, e;
  logic [15:0] d;
  ctrl_mode_t ctrl_mode;
  status_out_t status_in, status_out;
  int n_errors = 0;
  int compares = 0;
  int i, j;
  logic [7:0] codes [10] = '{`CODE_POS_DEV, `CODE_OVERHEAT, `CODE_OVERVOLT, `CODE_MAIN_OFF,
    `CODE_UNDERVOLT, `CODE_LOW_BATT, `CODE_OVERLOAD, `CODE_OVERSPEED, `CODE_ABS_LOST,
    `CODE_GEAR_ERR};
  always #12.5 clk_sys = ~clk_sys;
  servo_warning_alarm_monitor i_dut (.*);
  plc_model i_plc (.*);
  // ********
  // Tasks
  // ********
  task automatic w(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : w
  task automatic s(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : s
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic finish_test();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test
  initial begin
    meas = NOM;
    thresh = '{`DEF_POS_DEV_REV, `DEF_OVERHEAT_C, `DEF_OVERVOLT_V, `DEF_UNDERVOLT_V,
      `DEF_OVERLOAD_PCT, `DEF_OVERSPEED_RPM};
    {main_power_ok, batt_or_enc_lost, gear_range_err, hist_clear, alarm_event, clr_req} = 6'h20;
    {alarm_stops_excitation, brake_fitted, alarm_code_enable, code_table_we} = 4'hE;
    {torque_limit_active, speed_limit_active} = 2'h0;
    hist_index = 4'h0;
    alarm_id = 8'h05;
    alarm_blinks = 4'h2;
    code_table_waddr = 8'h05;
    code_table_wdata = 3'h6;
    ctrl_mode = CTRL_POSITION;
    status_in = 3'b100;
    w(8);
    chk(10'({alarm_out_n, hist_count, warning_out}), 10'h000);
    rst <= 1'b0;
    code_table_we <= 1'b1;
    s(1);
    chk(10'(alarm_out_n), 10'h001);
    w(1);
    code_table_we <= 1'b0;
    // Each cause set, then cleared; the seven measured ones at their threshold edge, then back to just not tripping
    for (i = 0; i < 10; i++) begin
      for (j = 0; j < 2; j++) begin
        w(1);
        d = 16'(1 - j);
        v = NOM;
        case (i)
          0: v.pos_dev_rev = `DEF_POS_DEV_REV + d;
          1: v.temp_c = `DEF_OVERHEAT_C + d;
          2: v.dc_bus_v = `DEF_OVERVOLT_V + d;
          4: v.dc_bus_v = `DEF_UNDERVOLT_V - d;
          5: v.batt_mv = `BATT_LOW_MV + 16'h0001 - d;
          6: v.torque_pct = `DEF_OVERLOAD_PCT + d;
          7: v.speed_rpm = `DEF_OVERSPEED_RPM + d;
          default: ;
        endcase
        meas <= v;
        main_power_ok <= !(i == 3 && d[0]);
        batt_or_enc_lost <= i == 8 && d[0];
        gear_range_err <= i == 9 && d[0];
        e = d[0] ? 10'h001 << i : 10'h000;
        s(1);
        chk(warn_active, e);
        chk(10'({warning_out, motor_current_enable}), {8'h00, d[0], 1'b1});
      end
    end
    for (i = 0; i < 10; i++) begin
      w(1);
      hist_index <= 4'(i);
      s(1);
      chk(10'(hist_code), 10'(codes[9 - i]));
    end
    chk(10'(hist_count), 10'h00A);
    w(1);
    v = NOM;
    v.temp_c = 16'h0051;
    meas <= v;
    hist_index <= 4'h0;
    s(3);
    chk(10'(hist_count), 10'h00A);
    chk(10'(hist_code), 10'(`CODE_OVERHEAT));
    w(1);
    hist_clear <= 1'b1;
    meas <= NOM;
    w(1);
    hist_clear <= 1'b0;
    s(2);
    chk(10'({hist_count, hist_code}), 10'h000);
    w(1);
    alarm_event <= 1'b1;
    w(1);
    alarm_event <= 1'b0;
    s(1);
    chk({alarm_out_n, motor_current_enable, brake_engage, status_out, 4'h0}, 10'h0B0);
    chk(10'(alarm_id_out), 10'h005);
    w(1);
    clr_req <= 1'b1;
    s(6);
    chk(10'(alarm_out_n), 10'h000);
    chk(10'(alarm_led), 10'h001);
    w(1);
    clr_req <= 1'b0;
    for (i = 0; alarm_out_n !== 1'b1; i++) begin
      if (i == 20) begin
        n_errors++;
        finish_test();
      end
      @(negedge clk_sys);
    end
    chk(10'({motor_current_enable, brake_engage}), 10'h002);
    for (i = 0; i < 4; i++) begin
      w(1);
      ctrl_mode <= ctrl_mode_t'(i);
      alarm_code_enable <= 1'b0;
      torque_limit_active <= i[0];
      speed_limit_active <= !i[0];
      s(1);
      chk(10'(status_out), {7'h00, 1'b1, i[1] ^ i[0], 1'b0});
    end
    chk(10'(alarm_led), 10'h000);
    finish_test();
  end
endmodule : tb
